// ==== design/dram_bank_pkg.sv ====
// constants for the banked dram timing controller
`default_nettype none
package dram_bank_pkg;
  // io port map
  localparam logic [7:0]  PORT_BANK_CTRL   = 8'h92;
  localparam logic [7:0]  PORT_BANK_STATUS = 8'h94;
  localparam logic [7:0]  PORT_BAUD_STATUS = 8'h95;
  // bank control fields
  localparam int          BANK_EN_BIT      = 7;
  localparam int          BANK_HALF_BIT    = 1;
  localparam logic        BANK_EN_RST      = 1'b0;
  localparam logic        BANK_HALF_RST    = 1'b0;
  // banked window in logical space
  localparam logic [15:0] WIN_LO           = 16'h4000;
  localparam logic [15:0] WIN_HI           = 16'hbfff;
  // ram geometry
  localparam int          MA_W             = 8;
  localparam int          ROWS             = 2;
  localparam int          ROW_LOWER        = 0;
  localparam int          ROW_UPPER        = 1;
  // idle values
  localparam logic [7:0]  BYTE_RST         = 8'h00;
  localparam logic [1:0]  STROBES_IDLE     = 2'h3;
endpackage
`default_nettype wire

// ==== design/banked_dram_timing_controller.sv ====
// dram row/column strobe timing, address multiplexing and bank ports
`default_nettype none
module banked_dram_timing_controller
  import dram_bank_pkg::*;
(
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // cpu bus pins
  input  wire logic             cpu_clk,
  input  wire logic             mreq_n,
  input  wire logic             iorq_n,
  input  wire logic             rd_n,
  input  wire logic             wr_n,
  input  wire logic             rfsh_n,
  input  wire logic [15:0]      addr,
  input  wire logic [7:0]       data_i,
  output logic      [7:0]       data_o,
  output logic                  data_oe,
  // baud latch contents
  input  wire logic [7:0]       baud_setting,
  // ram array
  output logic                  ras_n,
  output logic                  mux_sel,
  output logic      [MA_W-1:0]  ma_lower,
  output logic      [MA_W-1:0]  ma_upper,
  output logic      [ROWS-1:0]  cas_n,
  output logic      [ROWS-1:0]  we_n
);

  ////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers for every cpu bus and baud input pin
  logic [5:0]  ctl_s1_r;
  logic [5:0]  ctl_s2_r;
  logic [15:0] addr_s1_r;
  logic [15:0] addr_s2_r;
  logic [7:0]  data_s1_r;
  logic [7:0]  data_s2_r;
  logic [7:0]  baud_s1_r;
  logic [7:0]  baud_s2_r;
  logic        clk_d_r;
  logic        io_wr_d_r;
  logic        io_rd_d_r;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl_s1_r  <= 6'h1f;
      ctl_s2_r  <= 6'h1f;
      addr_s1_r <= 16'h0000;
      addr_s2_r <= 16'h0000;
      data_s1_r <= BYTE_RST;
      data_s2_r <= BYTE_RST;
      baud_s1_r <= BYTE_RST;
      baud_s2_r <= BYTE_RST;
    end
    else
    begin
      ctl_s1_r  <= {cpu_clk, mreq_n, iorq_n, rd_n, wr_n, rfsh_n};
      ctl_s2_r  <= ctl_s1_r;
      addr_s1_r <= addr;
      addr_s2_r <= addr_s1_r;
      data_s1_r <= data_i;
      data_s2_r <= data_s1_r;
      baud_s1_r <= baud_setting;
      baud_s2_r <= baud_s1_r;
    end
  end

  wire logic clk_s   = ctl_s2_r[5];
  wire logic mreq_s  = ctl_s2_r[4];
  wire logic iorq_s  = ctl_s2_r[3];
  wire logic rd_s    = ctl_s2_r[2];
  wire logic wr_s    = ctl_s2_r[1];
  wire logic rfsh_s  = ctl_s2_r[0];

  wire logic clk_rise = clk_s & ~clk_d_r;
  wire logic clk_fall = ~clk_s & clk_d_r;

  ////////////////////////////////////////////////////////////////////////
  // memory decode
  function automatic logic in_window(input logic [15:0] a);
    in_window = (a >= WIN_LO) && (a <= WIN_HI);
  endfunction

  logic        bank_en_r;
  logic        bank_half_r;
  logic        req_lat_r;
  logic        cas_en_n_r;
  logic [15:0] win_off;
  logic        sel_upper;

  // 16-bit logical address, full 64k span
  assign sel_upper = bank_en_r & in_window(addr_s2_r);
  assign win_off   = addr_s2_r - WIN_LO;

  // decoder selects a row only inside a memory cycle, never in refresh
  wire logic            dec_en  = ~mreq_s & rfsh_s;
  wire logic [ROWS-1:0] row_sel = !dec_en ? 2'b00 : sel_upper ? 2'b10 : 2'b01;

  ////////////////////////////////////////////////////////////////////////
  // strobe timing
  wire logic req_lat_nxt = !rfsh_s ? 1'b0 :
                           clk_rise ? ~mreq_s : req_lat_r;
  wire logic cas_en_nxt  = clk_fall ? ~req_lat_r : cas_en_n_r;

  // one column strobe per data byte row
  wire logic [ROWS-1:0] cas_nxt = {ROWS{cas_en_n_r}} | ~row_sel;
  wire logic [ROWS-1:0] we_nxt  = {ROWS{wr_s | mreq_s}} | ~row_sel;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_d_r    <= 1'b0;
      req_lat_r  <= 1'b0;
      cas_en_n_r <= 1'b1;
      cas_n      <= STROBES_IDLE;
      we_n       <= STROBES_IDLE;
    end
    else
    begin
      clk_d_r    <= clk_s;
      req_lat_r  <= req_lat_nxt;
      cas_en_n_r <= cas_en_nxt;
      cas_n      <= cas_nxt;
      we_n       <= we_nxt;
    end
  end

  // row strobe tracks the request, no cpu clock edge needed
  assign ras_n   = mreq_s;
  assign mux_sel = req_lat_r;

  // row then column; upper row column msb from held bank bit
  assign ma_lower = mux_sel ? addr_s2_r[15:8] : addr_s2_r[7:0];
  assign ma_upper = mux_sel ? {bank_half_r, win_off[14:8]} : addr_s2_r[7:0];

  ////////////////////////////////////////////////////////////////////////
  // io ports
  wire logic io_wr    = ~iorq_s & ~wr_s;
  wire logic io_rd    = ~iorq_s & ~rd_s;
  wire logic wr_start = io_wr & ~io_wr_d_r;
  wire logic hit_ctrl = addr_s2_r[7:0] == PORT_BANK_CTRL;
  wire logic hit_stat = addr_s2_r[7:0] == PORT_BANK_STATUS;
  wire logic hit_baud = addr_s2_r[7:0] == PORT_BAUD_STATUS;

  logic [7:0] status_byte;
  always_comb
  begin
    status_byte                = BYTE_RST;
    status_byte[BANK_EN_BIT]   = bank_en_r;
    status_byte[BANK_HALF_BIT] = bank_half_r;
  end

  wire logic [7:0] rd_nxt = hit_stat ? status_byte :
                            baud_s2_r;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bank_en_r   <= BANK_EN_RST;
      bank_half_r <= BANK_HALF_RST;
      io_wr_d_r   <= 1'b0;
      io_rd_d_r   <= 1'b0;
      data_o      <= BYTE_RST;
      data_oe     <= 1'b0;
    end
    else
    begin
      io_wr_d_r <= io_wr;
      io_rd_d_r <= io_rd;
      if (wr_start && hit_ctrl)
      begin
        bank_en_r   <= data_s2_r[BANK_EN_BIT];
        bank_half_r <= data_s2_r[BANK_HALF_BIT];
      end
      data_oe <= io_rd & (hit_stat | hit_baud);
      if (io_rd)
        data_o <= rd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  AST_RAS_BEFORE_COL: assert property ($fell(ras_n) |-> !mux_sel)
    else $error("row strobe fell with column address on mux");
  AST_MUX_ON_RISE: assert property (clk_rise && !mreq_s && rfsh_s |=> mux_sel)
    else $error("mux did not switch to column on cpu clock rise");
  AST_CAS_ON_FALL: assert property (clk_fall && req_lat_r && rfsh_s |=> !cas_en_n_r ##1 cas_n != STROBES_IDLE)
    else $error("column strobe missing after cpu clock fall");
  AST_REFRESH_ROW_ONLY: assert property (!rfsh_s [*3] |-> !mux_sel && cas_n == STROBES_IDLE)
    else $error("column activity during refresh");
  AST_CAS_ONE_ROW: assert property (cas_n != 2'b00)
    else $error("column strobe on both rows");
  AST_WE_ONE_ROW: assert property (!we_n[ROW_LOWER] |-> we_n[ROW_UPPER] && $past(!mreq_s))
    else $error("write strobe on wrong row or without request");
  AST_BANK_ENABLE: assert property (wr_start && hit_ctrl |=> bank_en_r == $past(data_s2_r[BANK_EN_BIT]))
    else $error("bank enable not taken from port write");
  AST_STATUS_READ: assert property (io_rd && hit_stat |=> data_oe && data_o[BANK_EN_BIT] == bank_en_r)
    else $error("bank status read wrong");
  AST_BAUD_READ: assert property (io_rd && hit_baud |=> data_oe && data_o == $past(baud_s2_r))
    else $error("baud readback wrong");
  AST_UPPER_NEEDS_BANK: assert property (!$past(bank_en_r) |-> cas_n[ROW_UPPER] && we_n[ROW_UPPER])
    else $error("upper row used while banking disabled");

endmodule
`default_nettype wire

// ==== verif/cpu_bus_model.sv ====
// cpu bus master model for the dram controller's bus pins
`default_nettype none
module cpu_bus_model (
  // clock
  input  wire logic        ref_clk,
  // cpu bus
  output logic             cpu_clk,
  output logic             mreq_n,
  output logic             iorq_n,
  output logic             rd_n,
  output logic             wr_n,
  output logic             rfsh_n,
  output logic [15:0]      addr,
  output logic [7:0]       data_i
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    {cpu_clk, mreq_n, iorq_n, rd_n, wr_n, rfsh_n} = 6'h1f;
    addr = 16'h0000;
    data_i = 8'hff;
  end
  // one bus phase: {clk, mreq, iorq, rd, wr, rfsh}, held six clocks
  task automatic drive(input logic [5:0] pins, input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #5;
    {cpu_clk, mreq_n, iorq_n, rd_n, wr_n, rfsh_n} = pins;
    addr = a;
    data_i = d;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// ==== verif/banked_dram_timing_controller_test.sv ====
// self-checking bench for the banked dram timing controller
`default_nettype none
module banked_dram_timing_controller_test
  import dram_bank_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic            ref_clk;
  logic            rst_n;
  logic [7:0]      baud_setting;
  wire             cpu_clk, mreq_n, iorq_n, rd_n, wr_n, rfsh_n, data_oe, ras_n, mux_sel;
  wire [15:0]      addr;
  wire [7:0]       data_i, data_o;
  wire [MA_W-1:0]  ma_lower, ma_upper;
  wire [ROWS-1:0]  cas_n, we_n;
  int              mismatches;
  int              check_count;
  always #25 ref_clk = ~ref_clk;
  cpu_bus_model cpu_u (.ref_clk(ref_clk), .cpu_clk(cpu_clk), .mreq_n(mreq_n), .iorq_n(iorq_n),
    .rd_n(rd_n), .wr_n(wr_n), .rfsh_n(rfsh_n), .addr(addr), .data_i(data_i));
  banked_dram_timing_controller dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .cpu_clk(cpu_clk),
    .mreq_n(mreq_n), .iorq_n(iorq_n), .rd_n(rd_n), .wr_n(wr_n), .rfsh_n(rfsh_n), .addr(addr),
    .data_i(data_i), .data_o(data_o), .data_oe(data_oe), .baud_setting(baud_setting),
    .ras_n(ras_n), .mux_sel(mux_sel), .ma_lower(ma_lower), .ma_upper(ma_upper),
    .cas_n(cas_n), .we_n(we_n));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic iow(input logic [7:0] p, input logic [7:0] d);
    cpu_u.drive(6'h15, {8'h00, p}, d);
    cpu_u.drive(6'h1f, {8'hff, ~p}, ~d);
  endtask
  task automatic ior(input logic [7:0] p, input logic [7:0] exp);
    cpu_u.drive(6'h13, {8'h00, p}, 8'hff);
    chk(data_oe, 1'b1);
    chk(data_o, exp);
    cpu_u.drive(6'h1f, {8'hff, ~p}, 8'h00);
    chk(data_oe, 1'b0);
  endtask
  // full memory cycle: row phase, cpu clock rise, fall, release
  task automatic mem(input logic [15:0] a, input logic w, input logic rf, input int row, input logic [7:0] col);
    logic [4:0] p;
    logic [1:0] sel;
    p = {1'b0, 1'b1, w | rf, ~w, ~rf};
    sel = rf ? 2'h3 : ~(2'h1 << row);
    cpu_u.drive({1'b0, p}, a, 8'h3c);
    chk(ras_n, 1'b0);
    chk(mux_sel, 1'b0);
    chk(row ? ma_upper : ma_lower, a[7:0]);
    cpu_u.drive({1'b1, p}, a, 8'h3c);
    chk(mux_sel, !rf);
    chk(row ? ma_upper : ma_lower, col);
    cpu_u.drive({1'b0, p}, a, 8'h3c);
    chk(cas_n, sel);
    chk(we_n, w ? sel : 2'h3);
    // a free-running cpu clock rises once more with the request gone
    cpu_u.drive(6'h3f, ~a, 8'hc3);
    chk(ras_n, 1'b1);
    chk(mux_sel, 1'b0);
    chk(we_n, 2'h3);
    cpu_u.drive(6'h1f, ~a, 8'hc3);
    chk(cas_n, 2'h3);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    baud_setting = 8'ha5;
    mismatches = 0;
    check_count = 0;
    repeat (4) @(posedge ref_clk);
    #5 rst_n = 1'b1;
    ior(PORT_BANK_STATUS, 8'h00);
    mem(16'h5a5a, 1'b0, 1'b0, ROW_LOWER, 8'h5a);
    iow(PORT_BANK_CTRL, 8'h82);
    ior(PORT_BANK_STATUS, 8'h82);
    ior(PORT_BAUD_STATUS, 8'ha5);
    mem(16'h3fff, 1'b1, 1'b0, ROW_LOWER, 8'h3f);
    mem(16'h4000, 1'b0, 1'b0, ROW_UPPER, 8'h80);
    mem(16'hbfff, 1'b1, 1'b0, ROW_UPPER, 8'hff);
    mem(16'hc012, 1'b1, 1'b0, ROW_LOWER, 8'hc0);
    mem(16'h7a35, 1'b0, 1'b1, ROW_LOWER, 8'h35);
    iow(PORT_BANK_CTRL, 8'h7e);
    ior(PORT_BANK_STATUS, 8'h02);
    mem(16'h6000, 1'b1, 1'b0, ROW_LOWER, 8'h60);
    iow(PORT_BANK_CTRL, 8'h80);
    mem(16'h4123, 1'b1, 1'b0, ROW_UPPER, 8'h01);
    tally_and_finish;
  end
  initial
  begin
    #1000000;
    mismatches++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
